// *** verilog/odr_pkg.sv ***
/*
  package for the display frame ram and command block: register map,
  reset values, command codes and link constants.
  assumes a 100 mhz core clock and an 8-bit wishbone byte address.
*/
`default_nettype none
package odr_pkg;
  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int COLS = 128;
  localparam int ROWS = 64;
  localparam int PAGES = 8;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_LEVELS = 8'h04;
  localparam logic [7:0] OFS_PIXSEL = 8'h08;
  localparam logic [7:0] OFS_PIXEL = 8'h0c;
  localparam logic [7:0] OFS_CURSOR = 8'h10;
  // ---------------------------------------------------------------
  // reset values and link address
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_CONTRAST = 8'h7f;
  localparam logic [7:0] RST_PUMP = 8'h10;
  localparam logic [5:0] RST_MUX = 6'h3f;
  localparam logic [5:0] RST_START = 6'h00;
  localparam logic [6:0] I2C_ADDR = 7'h3c;
  // ---------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_OFF = 8'hae;
  localparam logic [7:0] CMD_ON = 8'haf;
  localparam logic [7:0] CMD_START = 8'hd3;
  localparam logic [7:0] CMD_PUMP = 8'h8d;
  localparam logic [7:0] CMD_CONTRAST = 8'h81;
  localparam logic [7:0] CMD_MUX = 8'ha8;
  localparam logic [7:0] CMD_COL_NORM = 8'ha0;
  localparam logic [7:0] CMD_COL_REV = 8'ha1;
  localparam logic [7:0] CMD_ROW_NORM = 8'hc0;
  localparam logic [7:0] CMD_ROW_REV = 8'hc8;
  // ---------------------------------------------------------------
  // link states and pending arguments
  // ---------------------------------------------------------------
  typedef enum {ST_IDLE, ST_ADDR, ST_CTRL, ST_BODY, ST_SKIP} odr_state_t;
  typedef enum {ARG_NONE, ARG_START, ARG_PUMP, ARG_CONTRAST,
    ARG_MUX} odr_arg_t;
endpackage
`default_nettype wire

// *** verilog/odr_display_ram.sv ***
/*
  display frame ram with i2c command/data receiver and wishbone view.
  assumes scl, sda and the chip clear pin are asynchronous to core_clk
  and an external pull-up resolves the sda wire from sda_oe.
*/
// Overview of operation
// - frame ram holds 128 columns by 64 rows, one bit per pixel.
// - eight pages, each covering eight consecutive row outputs.
// - column and row mapping can each be reversed by command.
// - each data byte fills the eight-bit column at the pointer.
// - bit zero lands on the page's top row, bit seven bottom.
// - command d3h sets the start line shifting the shown image.
// - command aeh blanks the panel and keeps ram contents.
// - command afh turns the panel on showing retained ram.
// - chip clear pin resets internal logic.
// - configuration returns to defaults after chip clear pulse.
`default_nettype none
module odr_display_ram
  import odr_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // serial link pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // chip clear pin
  input wire logic chip_clear_input_n,
  // panel state
  output logic panel_on,
  output logic [7:0] contrast_level,
  output logic [7:0] pump_setting
);
  // ---------------------------------------------------------------
  // storage and state
  // ---------------------------------------------------------------
  logic [7:0] display_frame_ram [0:PAGES*COLS-1];
  logic [2:0] scl_s_r, sda_s_r, clr_s_r;
  odr_state_t st_r;
  odr_arg_t arg_r;
  logic [7:0] sh_r;
  logic [3:0] bit_r;
  logic ack_due_r, data_mode_r, ctl_again_r;
  logic col_rev_r, row_rev_r;
  logic [5:0] start_r, mux_r;
  logic [2:0] page_r;
  logic [6:0] col_r;
  logic [13:0] pixsel_r;
  logic [7:0] ram_q_r;
  logic [2:0] pbit_r;
  logic pend_r;
  logic scl_rise, scl_fall, start_c, stop_c, clr, byte_c;
  logic [7:0] sh_nxt;
  logic [5:0] mrow;
  logic [6:0] mcol;
  logic wb_req, wb_fire;

  // ---------------------------------------------------------------
  // pin synchronisers, third stage only for edge history
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
      clr_s_r <= 3'h7;
    end else begin
      scl_s_r <= {scl_s_r[1:0], scl_in};
      sda_s_r <= {sda_s_r[1:0], sda_in};
      clr_s_r <= {clr_s_r[1:0], chip_clear_input_n};
    end
  end

  // link events, read from stages two and three only
  assign clr = ~clr_s_r[1];
  assign scl_rise = scl_s_r[1] & ~scl_s_r[2];
  assign scl_fall = ~scl_s_r[1] & scl_s_r[2];
  assign start_c = scl_s_r[1] & scl_s_r[2] & ~sda_s_r[1] & sda_s_r[2];
  assign stop_c = scl_s_r[1] & scl_s_r[2] & sda_s_r[1] & ~sda_s_r[2];
  assign sh_nxt = {sh_r[6:0], sda_s_r[1]};
  assign byte_c = scl_rise & (bit_r == 4'h7) & (st_r != ST_IDLE);

  // ---------------------------------------------------------------
  // bit engine: shift, count and acknowledge
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sh_r <= 8'h00;
      bit_r <= 4'h0;
      ack_due_r <= 1'b0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
    end else if (clr || start_c || stop_c) begin
      bit_r <= 4'h0;
      sda_oe <= 1'b0;
      ack_due_r <= 1'b0;
    end else if (st_r != ST_IDLE) begin
      if (scl_rise && bit_r < 4'h8) begin
        sh_r <= sh_nxt;
        bit_r <= bit_r + 4'h1;
        // acknowledge own address in write direction, and all bytes after
        if (bit_r == 4'h7) begin
          ack_due_r <= (st_r == ST_ADDR) ?
            (sh_nxt == {I2C_ADDR, 1'b0}) : (st_r != ST_SKIP);
        end
      end else if (scl_fall && bit_r == 4'h8) begin
        sda_oe <= ack_due_r;
        bit_r <= 4'h9;
      end else if (scl_fall && bit_r == 4'h9) begin
        sda_oe <= 1'b0;
        bit_r <= 4'h0;
      end
    end
  end

  // ---------------------------------------------------------------
  // transfer sequencer: address, control byte, body
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r <= ST_IDLE;
      data_mode_r <= 1'b0;
      ctl_again_r <= 1'b0;
    end else if (clr || stop_c) begin
      st_r <= ST_IDLE;
    end else if (start_c) begin
      st_r <= ST_ADDR;
    end else if (byte_c) begin
      case (st_r)
        ST_ADDR: begin
          st_r <= (sh_nxt == {I2C_ADDR, 1'b0}) ? ST_CTRL : ST_SKIP;
        end
        ST_CTRL: begin
          data_mode_r <= sh_nxt[6];
          ctl_again_r <= sh_nxt[7];
          st_r <= ST_BODY;
        end
        ST_BODY: begin
          if (ctl_again_r) begin
            st_r <= ST_CTRL;
          end
        end
        default: begin
          st_r <= st_r;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // command decoder and configuration
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      panel_on <= 1'b0;
      col_rev_r <= 1'b0;
      row_rev_r <= 1'b0;
      start_r <= RST_START;
      mux_r <= RST_MUX;
      contrast_level <= RST_CONTRAST;
      pump_setting <= RST_PUMP;
      page_r <= 3'h0;
      col_r <= 7'h00;
      arg_r <= ARG_NONE;
    end else if (clr) begin
      // held at defaults for the whole low pulse
      panel_on <= 1'b0;
      col_rev_r <= 1'b0;
      row_rev_r <= 1'b0;
      start_r <= RST_START;
      mux_r <= RST_MUX;
      contrast_level <= RST_CONTRAST;
      pump_setting <= RST_PUMP;
      page_r <= 3'h0;
      col_r <= 7'h00;
      arg_r <= ARG_NONE;
    end else if (byte_c && st_r == ST_BODY && data_mode_r) begin
      col_r <= col_r + 7'h01;
    end else if (byte_c && st_r == ST_BODY) begin
      arg_r <= ARG_NONE;
      case (arg_r)
        ARG_START: start_r <= sh_nxt[5:0];
        ARG_PUMP: pump_setting <= sh_nxt;
        ARG_CONTRAST: contrast_level <= sh_nxt;
        ARG_MUX: mux_r <= sh_nxt[5:0];
        default: begin
          if (sh_nxt == CMD_OFF) begin
            panel_on <= 1'b0;
          end else if (sh_nxt == CMD_ON) begin
            panel_on <= 1'b1;
          end else if (sh_nxt == CMD_START) begin
            arg_r <= ARG_START;
          end else if (sh_nxt == CMD_PUMP) begin
            arg_r <= ARG_PUMP;
          end else if (sh_nxt == CMD_CONTRAST) begin
            arg_r <= ARG_CONTRAST;
          end else if (sh_nxt == CMD_MUX) begin
            arg_r <= ARG_MUX;
          end else if (sh_nxt == CMD_COL_NORM || sh_nxt == CMD_COL_REV) begin
            col_rev_r <= sh_nxt[0];
          end else if (sh_nxt == CMD_ROW_NORM || sh_nxt == CMD_ROW_REV) begin
            row_rev_r <= sh_nxt[3];
          end else if (sh_nxt[7:3] == 5'h16) begin
            page_r <= sh_nxt[2:0];
          end else if (sh_nxt[7:4] == 4'h0) begin
            col_r <= {col_r[6:4], sh_nxt[3:0]};
          end else if (sh_nxt[7:3] == 5'h02) begin
            col_r <= {sh_nxt[2:0], col_r[3:0]};
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // frame ram write, whole byte per column, lsb on top row
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (byte_c && st_r == ST_BODY && data_mode_r && !clr) begin
      display_frame_ram[{page_r, col_r}] <= sh_nxt;
    end
  end

  // ---------------------------------------------------------------
  // panel view: selected panel pixel through remap and start line
  // ---------------------------------------------------------------
  always_comb begin
    mrow = pixsel_r[13:8] + start_r;
    if (row_rev_r) begin
      mrow = 6'h3f - mrow;
    end
    mcol = col_rev_r ? (7'h7f - pixsel_r[6:0]) : pixsel_r[6:0];
  end

  always_ff @(posedge core_clk) begin
    ram_q_r <= display_frame_ram[{mrow[5:3], mcol}];
  end

  // ---------------------------------------------------------------
  // wishbone slave: ack two edges after the request
  // ---------------------------------------------------------------
  assign wb_req = wb_cyc_i & wb_stb_i;
  assign wb_fire = wb_req & pend_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pend_r <= 1'b0;
      wb_ack_o <= 1'b0;
      pbit_r <= 3'h0;
    end else begin
      pend_r <= wb_req & ~pend_r & ~wb_ack_o;
      wb_ack_o <= wb_fire;
      pbit_r <= mrow[2:0];
    end
  end

  // pixel select, the one writable register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pixsel_r <= 14'h0000;
    end else if (wb_fire && wb_we_i && wb_adr_i == OFS_PIXSEL) begin
      if (wb_sel_i[0]) begin
        pixsel_r[6:0] <= wb_dat_i[6:0];
      end
      if (wb_sel_i[1]) begin
        pixsel_r[13:8] <= wb_dat_i[13:8];
      end
    end
  end

  // read data, unmapped offsets read zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wb_dat_o <= 32'h00000000;
    end else if (wb_fire && !wb_we_i) begin
      if (wb_adr_i == OFS_STATUS) begin
        wb_dat_o <= {10'h000, mux_r, 2'h0, start_r, 5'h00, row_rev_r,
          col_rev_r, panel_on};
      end else if (wb_adr_i == OFS_LEVELS) begin
        wb_dat_o <= {16'h0000, pump_setting, contrast_level};
      end else if (wb_adr_i == OFS_PIXSEL) begin
        wb_dat_o <= {18'h00000, pixsel_r};
      end else if (wb_adr_i == OFS_PIXEL) begin
        wb_dat_o <= {31'h00000000, panel_on & ram_q_r[pbit_r]};
      end else if (wb_adr_i == OFS_CURSOR) begin
        wb_dat_o <= {21'h000000, page_r, 1'b0, col_r};
      end else begin
        wb_dat_o <= 32'h00000000;
      end
    end
  end
endmodule // odr_display_ram
`default_nettype wire

// *** test/odr_display_ram_checker.sv ***
/*
  port checker for odr_display_ram.
  assumes it is bound into every odr_display_ram instance.
*/
`default_nettype none
module odr_display_ram_checker
  import odr_pkg::*;
(
  // watched ports
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic chip_clear_input_n,
  input wire logic panel_on,
  input wire logic [7:0] contrast_level,
  input wire logic [7:0] pump_setting
);
  timeunit 1ns;
  timeprecision 1ns;
  // one clock domain
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // bus answer timing
  a_ack_delay: assert property ($rose(wb_cyc_i && wb_stb_i)
    |-> !wb_ack_o ##1 !wb_ack_o ##1 wb_ack_o) else $error("ack timing");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_stb_i, 2))
    else $error("ack without request");
  a_rdata_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o))
    else $error("read data moved");
  // configuration defaults
  a_reset_levels: assert property ($past(rst) |-> !panel_on &&
    contrast_level == RST_CONTRAST && pump_setting == RST_PUMP)
    else $error("reset levels wrong");
  a_clear_levels: assert property (!chip_clear_input_n [*4] |->
    !panel_on && contrast_level == RST_CONTRAST && pump_setting == RST_PUMP)
    else $error("clear levels wrong");
  // link acknowledge pin
  a_oe_span: assert property ($rose(sda_oe) |-> sda_oe [*8])
    else $error("ack pulse short");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("ack moved with clock high");
  a_out_low: assert property (sda_oe |-> !sda_out)
    else $error("sda driven high");
  // main scenarios
  c_ack: cover property (wb_ack_o);
  c_link_ack: cover property ($rose(sda_oe));
  c_panel_off: cover property ($fell(panel_on));
endmodule // odr_display_ram_checker
bind odr_display_ram odr_display_ram_checker u_chk (.core_clk, .rst,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o, .scl_in, .sda_out, .sda_oe,
  .chip_clear_input_n, .panel_on, .contrast_level, .pump_setting);
`default_nettype wire

// *** test/odr_host_model.sv ***
/*
  serial host model: drives clock, data release and chip clear pin.
  assumes the bench resolves the data wire with a pull-up.
*/
`default_nettype none
module odr_host_model (
  // link pins
  output logic scl,
  output logic sda_rel,
  input wire logic sda,
  // chip clear pin
  output logic clear_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus, clock stands high
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
    clear_n = 1'b1;
  end
  // one bit, data moves while clock low
  // bit period fixed at 160 ns to bound run length
  task automatic put(input logic b);
    sda_rel = b;
    #40 scl = 1'b1;
    #80 scl = 0;
    #40;
  endtask
  // start, bytes with acknowledge, stop
  task automatic frame(input logic [7:0] q[$], output int nacks);
    nacks = 0;
    #37 sda_rel = 1'b0;
    #40 scl = 1'b0;
    foreach (q[i]) begin
      for (int b = 7; b >= 0; b--) put(q[i][b]);
      sda_rel = 1'b1;
      #40 scl = 1'b1;
      #40 nacks += sda;
      #40 scl = 1'b0;
      #40;
    end
    sda_rel = 1'b0;
    #40 scl = 1'b1;
    #40 sda_rel = 1'b1;
    #1300;
  endtask
  // chip clear low pulse
  task automatic clear_pulse();
    // step off the core clock edge before moving the pin
    #3 clear_n = 1'b0;
    #3000 clear_n = 1'b1;
    #3000;
  endtask
endmodule // odr_host_model
`default_nettype wire

// *** test/odr_display_ram_tb.sv ***
/*
  self-checking bench for odr_display_ram.
  assumes odr_host_model on the link and a wishbone master here.
*/
`default_nettype none
module odr_display_ram_tb;
  import odr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_o, rdat;
  logic wb_ack_o, sda_out, sda_oe, panel_on, scl_in, sda_rel;
  logic chip_clear_input_n;
  logic [7:0] contrast_level, pump_setting;
  wire logic sda_in = sda_rel & ~sda_oe;
  int mismatches = 0;
  int check_count = 0;
  int nk;
  // core clock
  always #5 core_clk = ~core_clk;
  odr_display_ram u_odr_display_ram (.*);
  odr_host_model u_odr_host_model (.scl(scl_in), .sda_rel(sda_rel),
    .sda(sda_in), .clear_n(chip_clear_input_n));
  // compare and count
  task automatic chk(input logic [31:0] g, e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // one classic wishbone cycle
  task automatic wb(input logic w, input logic [7:0] a, input int d);
    int n;
    n = 0;
    @(posedge core_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge core_clk); while (wb_ack_o !== 1'b1 && ++n < 50);
    if (n >= 50) begin
      mismatches++;
      finish_test();
    end
    rdat = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    @(posedge core_clk);
  endtask
  // shown pixel at panel column and row
  task automatic pix(input int c, r, input logic e);
    wb(1, OFS_PIXSEL, (r << 8) | c);
    wb(0, OFS_PIXEL, 0);
    chk(rdat, {31'h0, e});
  endtask
  // one link frame to the device
  task automatic send(input logic [7:0] c, input logic [7:0] q[$]);
    u_odr_host_model.frame({8'h78, c, q}, nk);
    chk(nk, 0);
  endtask
  // register defaults and unmapped place
  task automatic t_reset();
    wb(0, OFS_STATUS, 0);
    chk(rdat, {10'h0, RST_MUX, 2'h0, RST_START, 8'h00});
    wb(0, OFS_LEVELS, 0);
    chk(rdat, {16'h0, RST_PUMP, RST_CONTRAST});
    wb(1, 8'h20, -1);
    wb(0, 8'h20, 0);
    chk(rdat, 0);
    $display("reset test done");
  endtask
  // byte fill, bit order, pointer advance and wrap
  task automatic t_fill();
    send(8'h00, '{8'hb0, 8'h00, 8'h10, 8'haf});
    send(8'h40, '{8'ha5, 8'h3c});
    send(8'h00, '{8'hb7, 8'h0f, 8'h17});
    send(8'h40, '{8'h81, 8'h01});
    for (int r = 0; r < 8; r++) begin
      pix(0, r, 8'ha5 >> r);
      pix(1, r, 8'h3c >> r);
    end
    pix(127, 56, 1);
    pix(127, 63, 1);
    pix(0, 56, 1);
    pix(0, 57, 0);
    wb(0, OFS_CURSOR, 0);
    chk(rdat, 32'h00000701);
    // chained control: one command byte, then a data control byte
    send(8'h80, '{8'hb1, 8'h40, 8'h5a});
    pix(1, 9, 1);
    pix(1, 8, 0);
    $display("fill test done");
  endtask
  // column and row reversal, start line
  task automatic t_map();
    send(8'h00, '{8'ha1, 8'hc8});
    wb(0, OFS_STATUS, 0);
    chk(rdat, {10'h0, RST_MUX, 13'h0, 3'h7});
    pix(127, 63, 1);
    pix(126, 63, 0);
    pix(0, 7, 1);
    send(8'h00, '{8'ha0, 8'hc0, 8'hd3, 8'h08});
    wb(0, OFS_STATUS, 0);
    chk(rdat, {10'h0, RST_MUX, 2'h0, 6'h08, 8'h01});
    pix(0, 56, 1);
    pix(1, 58, 1);
    send(8'h00, '{8'hd3, 8'h00});
    $display("map test done");
  endtask
  // off, on, pump and contrast sequences
  task automatic t_power();
    send(8'h00, '{8'hae});
    chk(panel_on, 0);
    pix(0, 0, 0);
    send(8'h00, '{8'h8d, 8'h95, 8'haf});
    pix(0, 0, 1);
    send(8'h00, '{8'h81, 8'hff, 8'ha8, 8'h27});
    wb(0, OFS_LEVELS, 0);
    chk(rdat, 32'h95ff);
    wb(0, OFS_STATUS, 0);
    chk(rdat, {10'h0, 6'h27, 16'h0001});
    send(8'h00, '{8'h81, 8'h01});
    chk(contrast_level, 8'h01);
    send(8'h00, '{8'hae, 8'h8d, 8'h10});
    chk({panel_on, pump_setting}, 9'h010);
    u_odr_host_model.frame('{8'h7a, 8'h00, 8'haf}, nk);
    chk(nk, 3);
    chk(panel_on, 0);
    $display("power test done");
  endtask
  // chip clear restores defaults, keeps ram
  task automatic t_clear();
    send(8'h00, '{8'haf, 8'h81, 8'h40, 8'ha1});
    u_odr_host_model.clear_pulse();
    wb(0, OFS_LEVELS, 0);
    chk(rdat, {16'h0, RST_PUMP, RST_CONTRAST});
    wb(0, OFS_STATUS, 0);
    chk(rdat, {10'h0, RST_MUX, 16'h0});
    send(8'h00, '{8'haf});
    pix(0, 0, 1);
    $display("clear test done");
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    t_reset();
    t_fill();
    t_map();
    t_power();
    t_clear();
    finish_test();
  end
endmodule // odr_display_ram_tb
`default_nettype wire
